// File: rtl/rtc_alarm_wdog.sv
// Alarm match, watchdog and frequency-test logic with its bytewide registers.
// What this block does
// R1: Test bit, alarm enable off, steering or zero watchdog: pin toggles at 512 Hz.
// R2: Power-up clears the frequency test bit.
// R3: Interrupt/test pin is open drain: pull low or release only.
// R4: Mask bits pick every second, seconds, min+sec, h+m+s, or date+h+m+s.
// R5: Any other mask pattern alarms once per second.
// R6: Alarm flag sets when unmasked time fields equal the alarm fields.
// R7: Match with alarm enable set pulls the interrupt pin low.
// R8: Any flags register access releases the alarm interrupt.
// R9: Alarm flag clears only when the flags access ends.
// R10: Host holds flags access a full read cycle to be sure of clearing.
// R11: In battery mode alarm pulls pin only with both enables set.
// R12: Power-up clears alarm enables; power-up alarms still set the flag.
// R13: Watchdog period is multiplier times 1/16, 1/4, 1 or 4 seconds.
// R14: Host touches the watchdog register within every period.
// R15: Time-out sets watchdog flag and interrupt until flag read or register access.
// R16: Steering zero sends time-out to the interrupt pin.
// R17: Steering one sends a 40 to 200 ms low reset pulse.
// R18: After a steered reset time-out, watchdog register and test bit clear.
// R19: Any watchdog register access restarts the period.
// R20: Watchdog register 00h disables the watchdog.
// R21: Power-up clears steering, multiplier, resolution and both alarm enables.
// R22: Watchdog on interrupt pin overrides the test frequency.
// R23: Seconds bit 7 stops the oscillator when 1, runs it when 0.
// R24: Frequency test bit is bit 6 of the day register.
// R25: Alarm enable is bit 7, backup enable bit 5 of alarm_enable_ctrl register.
// R26: Alarm compares once per one-second update.
// R27: Watchdog counts 1/16 s ticks from the 32.768 kHz oscillator.
`timescale 1ns/10ps
module rtc_alarm_wdog #(
    parameter int OSC_DIV = rtc_alarm_pkg::OSC_DIV
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rstn_in,
    // Bytewide memory bus pins, active low strobes.
    input wire logic [14:0] addr_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_n_out,
    // Timekeeping fields from the calendar, BCD.
    input wire logic [6:0] time_sec_in,
    input wire logic [6:0] time_min_in,
    input wire logic [5:0] time_hour_in,
    input wire logic [5:0] time_date_in,
    input wire logic second_tick_in,
    input wire logic battery_mode_in,
    // Oscillator run and 32.768 kHz oscillator tick derived here.
    output logic osc_run_out,
    output logic osc_tick_out,
    // Open-drain outputs: drive value is always 0, enable low pulls low.
    output logic alarm_wdog_int_out,
    output logic alarm_wdog_int_oe_n_out,
    output logic reset_out,
    output logic reset_oe_n_out
);
    logic rstn_m_r;
    logic rstn_r;
    logic [14:0] addr_s;
    logic [7:0] dq_s;
    logic [2:0] strb_s;
    logic ce_act;
    logic oe_act;
    logic we_act;
    logic acc_act;
    logic acc_prev_r;
    logic acc_rd_r;
    logic acc_end;
    logic wr_start;
    logic [14:0] acc_addr_r;
    logic [7:0] alm_sec_r;
    logic [7:0] alm_min_r;
    logic [7:0] alm_hour_r;
    logic [7:0] alm_date_r;
    logic alarm_int_enable;
    logic alarm_backup_enable;
    logic [7:0] int_other_r;
    logic [7:0] wdog_r;
    logic freq_test_bit;
    logic clock_halt_bit;
    logic alarm_match_flag;
    logic wdog_timeout_flag;
    logic alarm_irq_r;
    logic flags_acc;
    logic wdog_acc;
    logic [3:0] alarm_mask_bits;
    logic alarm_hit;
    logic alm_sec_ok;
    logic alm_min_ok;
    logic alm_hour_ok;
    logic alm_date_ok;
    logic alarm_event;
    logic [11:0] tick_cnt_r;
    logic tick16;
    logic [12:0] wd_cnt_r;
    logic [12:0] wd_period;
    logic wd_enabled;
    logic wd_expire;
    logic [11:0] rst_cnt_r;
    logic rst_active;
    logic rst_end;
    logic [4:0] tone_cnt_r;
    logic tone_phase_r;
    logic tone_on;
    logic wdog_output_select;
    logic [4:0] wdog_multiplier;
    logic [1:0] wdog_resolution;
    logic int_low;
    logic [7:0] rd_data;

    // Reset release through two flops; assertion stays asynchronous.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rstn_m_r <= 1'b0;
            rstn_r <= 1'b0;
        end
        else
        begin
            rstn_m_r <= 1'b1;
            rstn_r <= rstn_m_r;
        end
    end

    // Pins are asynchronous to our clock, so they pass four flops.
    rtc_sync3 #(.W(15), .INIT(15'h0000)) u_addr_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_r),
        .async_in(addr_in),
        .sync_out(addr_s)
    );
    rtc_sync3 #(.W(3), .INIT(3'h7)) u_strb_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_r),
        .async_in({ce_n_in, oe_n_in, we_n_in}),
        .sync_out(strb_s)
    );
    // Data shares the strobes' latency, so the last write cycle never takes new data.
    rtc_sync3 #(.W(8), .INIT(8'hFF)) u_data_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_r),
        .async_in(dq_in),
        .sync_out(dq_s)
    );
    rtc_osc_divider #(.DIV(OSC_DIV)) u_osc (
        .clk_in(clk_in),
        .rstn_in(rstn_r),
        .run_in(osc_run_out),
        .osc_tick_out(osc_tick_out)
    );

    // Access decode; an access is chip enable with either strobe.
    assign ce_act = !strb_s[2];
    assign oe_act = !strb_s[1];
    assign we_act = !strb_s[0];
    assign acc_act = ce_act && (oe_act || we_act);
    assign acc_end = acc_prev_r && !acc_act;
    assign wr_start = acc_act && we_act;
    assign flags_acc = acc_act && (addr_s == rtc_alarm_pkg::FLAGS_ADDR);
    assign wdog_acc = acc_act && (addr_s == rtc_alarm_pkg::WDOG_ADDR);
    assign osc_run_out = !clock_halt_bit; // R23
    assign alarm_int_enable = int_other_r[rtc_alarm_pkg::ALM_EN_BIT]; // R25
    assign alarm_backup_enable = int_other_r[rtc_alarm_pkg::BAK_EN_BIT]; // R25
    assign wdog_output_select = wdog_r[rtc_alarm_pkg::STEER_BIT];
    assign wdog_multiplier = wdog_r[6:2];
    assign wdog_resolution = wdog_r[1:0];

    // Track the access and the address it ended on.
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            acc_prev_r <= 1'b0;
            acc_rd_r <= 1'b0;
            acc_addr_r <= 15'h0000;
        end
        else
        begin
            acc_prev_r <= acc_act;
            if (acc_act)
            begin
                acc_addr_r <= addr_s;
                acc_rd_r <= !we_act;
            end
        end
    end

    // Mask decode; undefined patterns fall back to every second.
    assign alarm_mask_bits = {alm_date_r[rtc_alarm_pkg::MASK_BIT],
        alm_hour_r[rtc_alarm_pkg::MASK_BIT], alm_min_r[rtc_alarm_pkg::MASK_BIT],
        alm_sec_r[rtc_alarm_pkg::MASK_BIT]};
    assign alm_sec_ok = time_sec_in == alm_sec_r[6:0];
    assign alm_min_ok = time_min_in == alm_min_r[6:0];
    assign alm_hour_ok = time_hour_in == alm_hour_r[5:0];
    assign alm_date_ok = time_date_in == alm_date_r[5:0];
    always_comb
    begin
        unique case (alarm_mask_bits) // R4
            4'hE: alarm_hit = alm_sec_ok;
            4'hC: alarm_hit = alm_sec_ok && alm_min_ok;
            4'h8: alarm_hit = alm_sec_ok && alm_min_ok && alm_hour_ok;
            4'h0: alarm_hit = alm_sec_ok && alm_min_ok && alm_hour_ok && alm_date_ok;
            default: alarm_hit = 1'b1; // R5
        endcase
    end
    assign alarm_event = second_tick_in && alarm_hit; // R26

    // Flags: set wins over the clear at the end of a flags access.
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            alarm_match_flag <= 1'b0;
            wdog_timeout_flag <= 1'b0;
        end
        else
        begin
            if (alarm_event)
                alarm_match_flag <= 1'b1; // R6 R12
            else if (acc_end && acc_addr_r == rtc_alarm_pkg::FLAGS_ADDR)
                alarm_match_flag <= 1'b0; // R9
            if (wd_expire)
                wdog_timeout_flag <= 1'b1; // R15
            else if ((acc_end && acc_rd_r && acc_addr_r == rtc_alarm_pkg::FLAGS_ADDR)
                     || wdog_acc)
                wdog_timeout_flag <= 1'b0; // R15
        end
    end

    // Alarm interrupt is released as soon as the flags access begins.
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
            alarm_irq_r <= 1'b0;
        else if (alarm_event && alarm_int_enable
                 && (!battery_mode_in || alarm_backup_enable)) // R7 R11
            alarm_irq_r <= 1'b1;
        else if (flags_acc)
            alarm_irq_r <= 1'b0; // R8
    end

    // Register writes; power-up defaults clear enables and the watchdog.
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            alm_sec_r <= 8'h00;
            alm_min_r <= 8'h00;
            alm_hour_r <= 8'h00;
            alm_date_r <= 8'h00;
            int_other_r <= 8'h00; // R12 R21
            wdog_r <= rtc_alarm_pkg::WDOG_RESET; // R21
            freq_test_bit <= 1'b0; // R2
            clock_halt_bit <= rtc_alarm_pkg::HALT_RESET;
        end
        else if (rst_end)
        begin
            wdog_r <= rtc_alarm_pkg::WDOG_RESET; // R18
            freq_test_bit <= 1'b0; // R18
        end
        else if (wr_start)
        begin
            unique case (addr_s)
                rtc_alarm_pkg::ALM_SEC_ADDR: alm_sec_r <= dq_s;
                rtc_alarm_pkg::ALM_MIN_ADDR: alm_min_r <= dq_s;
                rtc_alarm_pkg::ALM_HOUR_ADDR: alm_hour_r <= dq_s;
                rtc_alarm_pkg::ALM_DATE_ADDR: alm_date_r <= dq_s;
                rtc_alarm_pkg::INT_ADDR: int_other_r <= dq_s;
                rtc_alarm_pkg::WDOG_ADDR: wdog_r <= dq_s;
                rtc_alarm_pkg::DAY_ADDR: freq_test_bit <= dq_s[rtc_alarm_pkg::TONE_BIT]; // R24
                rtc_alarm_pkg::SEC_ADDR: clock_halt_bit <= dq_s[rtc_alarm_pkg::HALT_BIT]; // R23
                default: ;
            endcase
        end
    end

    // 1/16 s tick from oscillator edges.
    assign tick16 = osc_tick_out && (tick_cnt_r == 12'(rtc_alarm_pkg::OSC_PER_TICK - 1)); // R27
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
            tick_cnt_r <= 12'h000;
        else if (wdog_acc)
            tick_cnt_r <= 12'h000; // R19
        else if (osc_tick_out)
            tick_cnt_r <= tick16 ? 12'h000 : tick_cnt_r + 12'h001;
    end

    // Period in 1/16 s ticks: multiplier times resolution.
    always_comb
    begin
        unique case (wdog_resolution) // R13
            2'h0: wd_period = 13'(wdog_multiplier) * 13'(rtc_alarm_pkg::RES_TICKS_0);
            2'h1: wd_period = 13'(wdog_multiplier) * 13'(rtc_alarm_pkg::RES_TICKS_1);
            2'h2: wd_period = 13'(wdog_multiplier) * 13'(rtc_alarm_pkg::RES_TICKS_2);
            2'h3: wd_period = 13'(wdog_multiplier) * 13'(rtc_alarm_pkg::RES_TICKS_3);
        endcase
    end
    // A zero multiplier gives no period, so it disables like 00h.
    assign wd_enabled = (wdog_r != 8'h00) && (wd_period != 13'h0000); // R20
    assign wd_expire = wd_enabled && tick16 && !rst_active
                       && (wd_cnt_r == wd_period - 13'h0001);

    // Watchdog counter, restarted by any access to its register.
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
            wd_cnt_r <= 13'h0000;
        else if (wdog_acc || !wd_enabled || wd_expire)
            wd_cnt_r <= 13'h0000; // R19
        else if (tick16 && !rst_active)
            wd_cnt_r <= wd_cnt_r + 13'h0001;
    end

    // Reset pulse in oscillator ticks; one spare tick covers the partial first one.
    assign rst_active = rst_cnt_r != 12'h000;
    assign rst_end = osc_tick_out && (rst_cnt_r == 12'h001);
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
            rst_cnt_r <= 12'h000;
        else if (wd_expire && wdog_output_select)
            rst_cnt_r <= 12'(rtc_alarm_pkg::RST_PULSE_OSC + 1); // R17
        else if (osc_tick_out && rst_active)
            rst_cnt_r <= rst_cnt_r - 12'h001;
    end

    // 512 Hz square wave: toggle every 32 oscillator cycles.
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            tone_cnt_r <= 5'h00;
            tone_phase_r <= 1'b0;
        end
        else if (osc_tick_out)
        begin
            tone_cnt_r <= tone_cnt_r + 5'h01;
            if (tone_cnt_r == 5'(rtc_alarm_pkg::OSC_PER_TONE_HALF - 1))
                tone_phase_r <= !tone_phase_r; // R1
        end
    end
    assign tone_on = freq_test_bit && !alarm_int_enable && osc_run_out
                     && (wdog_output_select || wdog_r == 8'h00); // R1

    // Pin merge: a watchdog flag routed to this pin (steering zero) wins over the test tone.
    assign int_low = alarm_irq_r
                     || (wdog_timeout_flag && !wdog_output_select) // R16 R22
                     || (tone_on && !(wdog_timeout_flag && !wdog_output_select) && tone_phase_r);
    assign alarm_wdog_int_out = 1'b0; // R3
    assign alarm_wdog_int_oe_n_out = !int_low; // R3
    assign reset_out = 1'b0;
    assign reset_oe_n_out = !rst_active; // R17

    // Read data; unmapped addresses read zero.
    always_comb
    begin
        unique case (addr_s)
            rtc_alarm_pkg::FLAGS_ADDR: rd_data = {wdog_timeout_flag, alarm_match_flag, 6'h00};
            rtc_alarm_pkg::ALM_SEC_ADDR: rd_data = alm_sec_r;
            rtc_alarm_pkg::ALM_MIN_ADDR: rd_data = alm_min_r;
            rtc_alarm_pkg::ALM_HOUR_ADDR: rd_data = alm_hour_r;
            rtc_alarm_pkg::ALM_DATE_ADDR: rd_data = alm_date_r;
            rtc_alarm_pkg::INT_ADDR: rd_data = int_other_r;
            rtc_alarm_pkg::WDOG_ADDR: rd_data = wdog_r;
            rtc_alarm_pkg::SEC_ADDR: rd_data = {clock_halt_bit, 7'h00};
            rtc_alarm_pkg::DAY_ADDR: rd_data = {1'b0, freq_test_bit, 6'h00};
            default: rd_data = 8'h00;
        endcase
    end
    always_ff @(posedge clk_in or negedge rstn_r)
    begin
        if (!rstn_r)
            dq_out <= 8'h00;
        else
            dq_out <= rd_data;
    end
    assign dq_oe_n_out = !(acc_act && oe_act && !we_act);

    // Checks.
    flag_release_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        flags_acc && !alarm_event |=> !alarm_irq_r) else $error("irq not released"); // R8
    flag_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        alarm_match_flag && acc_act && !acc_end |=> alarm_match_flag)
        else $error("alarm flag cleared early"); // R9
    alarm_set_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        alarm_event |=> alarm_match_flag) else $error("alarm flag not set"); // R6
    bad_mask_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        !(alarm_mask_bits inside {4'hF, 4'hE, 4'hC, 4'h8, 4'h0}) |-> alarm_hit)
        else $error("bad mask not every second"); // R5
    wd_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        wd_expire |=> wdog_timeout_flag) else $error("watchdog flag missing"); // R15
    wd_restart_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        wdog_acc |=> wd_cnt_r == 13'h0000) else $error("watchdog not restarted"); // R19
    rst_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        wd_expire && wdog_output_select |=> !reset_oe_n_out)
        else $error("reset pulse missing"); // R17
    rst_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        rst_end |=> wdog_r == 8'h00 && !freq_test_bit)
        else $error("watchdog not cleared"); // R18
    wd_off_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        wdog_r == 8'h00 |-> !wd_expire) else $error("disabled watchdog fired"); // R20
    drain_only_a: assert property (@(posedge clk_in) disable iff (!rstn_r)
        !alarm_wdog_int_out && !reset_out) else $error("pin driven high"); // R3
endmodule // rtc_alarm_wdog

// File: rtl/rtc_alarm_pkg.sv
// Constants shared by the alarm, watchdog and frequency-test logic.
package rtc_alarm_pkg;
    // Register addresses on the bytewide memory bus.
    localparam logic [14:0] FLAGS_ADDR = 15'h7FF0;
    localparam logic [14:0] ALM_SEC_ADDR = 15'h7FF2;
    localparam logic [14:0] ALM_MIN_ADDR = 15'h7FF3;
    localparam logic [14:0] ALM_HOUR_ADDR = 15'h7FF4;
    localparam logic [14:0] ALM_DATE_ADDR = 15'h7FF5;
    localparam logic [14:0] INT_ADDR = 15'h7FF6;
    localparam logic [14:0] WDOG_ADDR = 15'h7FF7;
    localparam logic [14:0] SEC_ADDR = 15'h7FF9;
    localparam logic [14:0] DAY_ADDR = 15'h7FFC;
    // Field positions.
    localparam int WD_FLAG_BIT = 7;
    localparam int ALM_FLAG_BIT = 6;
    localparam int ALM_EN_BIT = 7;
    localparam int BAK_EN_BIT = 5;
    localparam int STEER_BIT = 7;
    localparam int TONE_BIT = 6;
    localparam int HALT_BIT = 7;
    localparam int MASK_BIT = 7;
    // Values after power-up.
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam logic HALT_RESET = 1'b1;
    // Timing: 32.768 kHz oscillator, 1/16 s tick, 512 Hz test toggle.
    localparam int CLK_HZ = 100_000_000;
    localparam int OSC_HZ = 32768;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int OSC_PER_TICK = OSC_HZ / 16;
    localparam int OSC_PER_TONE_HALF = OSC_HZ / 1024;
    localparam int TICKS_PER_SEC = 16;
    localparam int RST_PULSE_MIN_MS = 40;
    localparam int RST_PULSE_MAX_MS = 200;
    localparam int RST_PULSE_OSC = (RST_PULSE_MIN_MS * OSC_HZ + 999) / 1000;
    // Resolution codes in 1/16 s ticks.
    localparam logic [7:0] RES_TICKS_0 = 8'h01;
    localparam logic [7:0] RES_TICKS_1 = 8'h04;
    localparam logic [7:0] RES_TICKS_2 = 8'h10;
    localparam logic [7:0] RES_TICKS_3 = 8'h40;
endpackage

// File: rtl/rtc_osc_divider.sv
// Divider making the 32.768 kHz oscillator enable from the system clock.
`timescale 1ns/10ps
module rtc_osc_divider #(
    parameter int DIV = rtc_alarm_pkg::OSC_DIV
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rstn_in,
    // Run control and enable pulse.
    input wire logic run_in,
    output logic osc_tick_out
);
    logic [15:0] count_r;
    logic wrap;

    // A halted oscillator holds its phase, like a stopped crystal.
    assign wrap = (count_r == 16'(DIV - 1));
    assign osc_tick_out = run_in && wrap;

    // Free count while running.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            count_r <= 16'h0000;
        else if (run_in)
            count_r <= wrap ? 16'h0000 : count_r + 16'h0001;
    end
endmodule // rtc_osc_divider

// File: rtl/rtc_sync3.sv
// Three-stage synchroniser; a change counts once stages two and three agree.
`timescale 1ns/10ps
module rtc_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rstn_in,
    // Raw and filtered levels.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] hold_r;

    // Stage one is seen only by stage two, so metastability never leaks.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            hold_r <= INIT;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++)
                if (s2_r[i] == s3_r[i])
                    hold_r[i] <= s3_r[i];
        end
    end
    assign sync_out = hold_r;
endmodule // rtc_sync3

// File: bench/rtc_host_model.sv
// Host processor model that drives the bytewide bus pins of the alarm block.
`timescale 1ns/10ps
module rtc_host_model (
    // Clock.
    input wire logic clk_in,
    // Bus pins towards the device.
    output logic [14:0] addr_out,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [7:0] dq_out,
    // Read data from the device.
    input wire logic [7:0] dq_in
);
    // Bus idles with every strobe high.
    initial
    begin
        addr_out = 15'h0000;
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        we_n_out = 1'b1;
        dq_out = 8'hFF;
    end
    // One access; strobes stay low eight clocks, well past the device's pin filter.
    task automatic access(input logic [14:0] a, input logic wr, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(posedge clk_in);
        #1;
        addr_out = a;
        dq_out = wd;
        ce_n_out = 1'b0;
        oe_n_out = wr;
        we_n_out = !wr;
        repeat (8) @(posedge clk_in);
        rd = dq_in;
        #1;
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        we_n_out = 1'b1;
        dq_out = ~wd; // Released data lines must not keep the old value.
        repeat (6) @(posedge clk_in); // The filtered release and end-of-access clears land first.
    endtask
endmodule // rtc_host_model

// File: bench/rtc_alarm_watchdog_irq_tb.sv
// Self-checking bench for the alarm, watchdog and frequency-test block.
`timescale 1ns/10ps
module rtc_alarm_watchdog_irq_tb;
    // A small divider keeps watchdog and reset-pulse waits short.
    localparam int DIV = 4;
    localparam int TICK = rtc_alarm_pkg::OSC_PER_TICK * DIV;
    localparam int HALF = rtc_alarm_pkg::OSC_PER_TONE_HALF * DIV;
    localparam int RMIN = rtc_alarm_pkg::RST_PULSE_OSC * DIV;
    localparam int RMAX = rtc_alarm_pkg::OSC_HZ / 5 * DIV;
    logic clk_in, rstn_in, tick, batt, ce_n, oe_n, we_n;
    logic dq_oe_n, run, otick, irq_o, irq_oe_n, rst_o, rst_oe_n;
    logic [6:0] t_sec;
    logic [14:0] addr;
    logic [7:0] dq_w, dq_r, v;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    // Both open-drain pins are pulled up on the board.
    wire irq_pin = irq_oe_n ? 1'b1 : irq_o;
    wire rst_pin = rst_oe_n ? 1'b1 : rst_o;
    // Free-running 100 MHz clock.
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    rtc_alarm_wdog #(.OSC_DIV(DIV)) u_rtc_alarm_wdog (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(addr), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .dq_in(dq_w),
        .dq_out(dq_r), .dq_oe_n_out(dq_oe_n), .time_sec_in(t_sec), .time_min_in(7'h00),
        .time_hour_in(6'h00), .time_date_in(6'h00), .second_tick_in(tick),
        .battery_mode_in(batt), .osc_run_out(run), .osc_tick_out(otick),
        .alarm_wdog_int_out(irq_o), .alarm_wdog_int_oe_n_out(irq_oe_n),
        .reset_out(rst_o), .reset_oe_n_out(rst_oe_n));
    rtc_host_model u_rtc_host_model (.clk_in(clk_in), .addr_out(addr), .ce_n_out(ce_n),
        .oe_n_out(oe_n), .we_n_out(we_n), .dq_out(dq_w), .dq_in(dq_r));
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] junk;
        u_rtc_host_model.access(a, 1'b1, d, junk);
    endtask
    task automatic rd(input logic [14:0] a, output logic [7:0] d);
        u_rtc_host_model.access(a, 1'b0, 8'h00, d);
    endtask
    // One-second update with a new seconds value.
    task automatic pulse(input logic [6:0] s);
        @(posedge clk_in);
        #1;
        t_sec = s;
        tick = 1'b1;
        @(posedge clk_in);
        #1;
        tick = 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    // Bounded wait for a pin level; c reaches lim if it never comes.
    task automatic wait_lvl(input logic sel, input logic lvl, input int lim, output int c);
        c = 0;
        while (((sel ? rst_pin : irq_pin) !== lvl) && c < lim)
        begin
            @(posedge clk_in);
            c++;
        end
    endtask
    task automatic toggles(input int len, output int c);
        logic p;
        c = 0;
        p = irq_pin;
        repeat (len)
        begin
            @(posedge clk_in);
            if (irq_pin !== p) c++;
            p = irq_pin;
        end
    endtask
    // A hang ends the run as a failure.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            end_of_test();
        end
    end
    initial
    begin
        rstn_in = 1'b0;
        tick = 1'b0;
        batt = 1'b0;
        t_sec = 7'h00;
        repeat (12) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        repeat (8) @(posedge clk_in);
        rd(rtc_alarm_pkg::WDOG_ADDR, v);
        chk_byte(v, 8'h00);
        rd(rtc_alarm_pkg::INT_ADDR, v);
        chk_byte(v & 8'hA0, 8'h00);
        rd(rtc_alarm_pkg::DAY_ADDR, v);
        chk_pin(v[6], 1'b0);
        wr(rtc_alarm_pkg::SEC_ADDR, 8'h00);
        chk_pin(run, 1'b1);
        // Seconds-match alarm: mask 1110.
        wr(rtc_alarm_pkg::ALM_SEC_ADDR, 8'h15);
        wr(rtc_alarm_pkg::ALM_MIN_ADDR, 8'h80);
        wr(rtc_alarm_pkg::ALM_HOUR_ADDR, 8'h80);
        wr(rtc_alarm_pkg::ALM_DATE_ADDR, 8'h80);
        wr(rtc_alarm_pkg::INT_ADDR, 8'h80);
        pulse(7'h14);
        chk_pin(irq_pin, 1'b1);
        pulse(7'h15);
        chk_pin(irq_pin, 1'b0);
        chk_pin(irq_o, 1'b0);
        rd(rtc_alarm_pkg::FLAGS_ADDR, v);
        chk_pin(v[6], 1'b1);
        chk_pin(irq_pin, 1'b1);
        rd(rtc_alarm_pkg::FLAGS_ADDR, v);
        chk_pin(v[6], 1'b0);
        // Masks 1100, 1000, 0000: one field off blocks the alarm.
        wr(rtc_alarm_pkg::ALM_MIN_ADDR, 8'h01);
        pulse(7'h15);
        wr(rtc_alarm_pkg::ALM_HOUR_ADDR, 8'h01);
        wr(rtc_alarm_pkg::ALM_MIN_ADDR, 8'h00);
        pulse(7'h15);
        wr(rtc_alarm_pkg::ALM_DATE_ADDR, 8'h01);
        wr(rtc_alarm_pkg::ALM_HOUR_ADDR, 8'h00);
        pulse(7'h15);
        chk_pin(irq_pin, 1'b1);
        wr(rtc_alarm_pkg::ALM_DATE_ADDR, 8'h00);
        pulse(7'h15);
        chk_pin(irq_pin, 1'b0);
        rd(rtc_alarm_pkg::FLAGS_ADDR, v);
        // Undefined mask 1010 falls back to every second.
        wr(rtc_alarm_pkg::ALM_DATE_ADDR, 8'h80);
        wr(rtc_alarm_pkg::ALM_MIN_ADDR, 8'h80);
        pulse(7'h14);
        chk_pin(irq_pin, 1'b0);
        rd(rtc_alarm_pkg::FLAGS_ADDR, v);
        batt = 1'b1;
        pulse(7'h16);
        chk_pin(irq_pin, 1'b1);
        rd(rtc_alarm_pkg::FLAGS_ADDR, v);
        chk_pin(v[6], 1'b1);
        batt = 1'b0;
        // Frequency test: ten half periods give ten edges.
        wr(rtc_alarm_pkg::INT_ADDR, 8'h00);
        wr(rtc_alarm_pkg::DAY_ADDR, 8'h40);
        toggles(10 * HALF, n);
        chk_byte(8'(n), 8'h0A);
        // Watchdog to the interrupt pin, one 1/16 s step, restarted halfway.
        wr(rtc_alarm_pkg::WDOG_ADDR, 8'h04);
        toggles(4 * HALF, n);
        chk_byte(8'(n), 8'h00);
        repeat (4000) @(posedge clk_in);
        rd(rtc_alarm_pkg::WDOG_ADDR, v);
        wait_lvl(1'b0, 1'b0, 9000, n);
        chk_pin(n > TICK - 200 && n < TICK + 50, 1'b1);
        repeat (50) @(posedge clk_in);
        chk_pin(irq_pin, 1'b0);
        rd(rtc_alarm_pkg::FLAGS_ADDR, v);
        chk_pin(v[7], 1'b1);
        chk_pin(irq_pin, 1'b1);
        // Watchdog steered to the reset pin.
        wr(rtc_alarm_pkg::WDOG_ADDR, 8'h84);
        wait_lvl(1'b1, 1'b0, 9000, n);
        chk_pin(n > TICK - 200 && n < TICK + 50, 1'b1);
        wait_lvl(1'b1, 1'b1, RMAX + 10, n);
        chk_pin(n >= RMIN && n <= RMAX, 1'b1);
        rd(rtc_alarm_pkg::WDOG_ADDR, v);
        chk_byte(v, 8'h00);
        rd(rtc_alarm_pkg::DAY_ADDR, v);
        chk_pin(v[6], 1'b0);
        wait_lvl(1'b1, 1'b0, TICK + 500, n);
        chk_pin(n == TICK + 500 && irq_pin === 1'b1, 1'b1);
        end_of_test();
    end
endmodule // rtc_alarm_watchdog_irq_tb
